/* File: hw/tim_pkg.sv */
package tim_pkg;

    // ==========================================
    // Timing
    // ==========================================
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned WAKE_LOW_US = 200;
    // Wake-up pulse length in clock cycles
    localparam int unsigned WAKE_LOW_CYC = (CLK_HZ / 1_000_000) * WAKE_LOW_US;
    localparam int unsigned WAKE_CNT_W = 14;

    // ==========================================
    // Current limit choices, in mA
    // ==========================================
    localparam int unsigned LIMIT_HIGH_MA = 200;
    localparam int unsigned LIMIT_LOW_MA = 100;

    // ==========================================
    // Driver modes
    // ==========================================
    typedef enum logic [1:0] {
        TIM_HIGH_SIDE,
        TIM_LOW_SIDE,
        TIM_PUSH_PULL
    } tim_drive_type;

    // Line request
    typedef enum logic [1:0] {
        TIM_REQ_FLOAT,
        TIM_REQ_LOW,
        TIM_REQ_HIGH
    } tim_req_type;

endpackage : tim_pkg

/* File: hw/tim_sync.sv */
`timescale 1ns/10ps
// ==========================================
// Two-flop synchroniser, one per bit
// ==========================================
module tim_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage read only by the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : tim_sync

/* File: hw/tim_wake_pulse.sv */
`timescale 1ns/10ps
// ==========================================
// Wake-up low pulse stretcher
// ==========================================
module tim_wake_pulse
    import tim_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Detector event and pulse
    input wire logic wake_event,
    output logic wake_active
);
    logic [WAKE_CNT_W-1:0] cnt_q;

    // Restart on each event; active while counting down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (wake_event) begin
                cnt_q <= WAKE_CNT_W'(WAKE_LOW_CYC);
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - WAKE_CNT_W'(1);
            end
        end
    end

    assign wake_active = (cnt_q != '0);
endmodule : tim_wake_pulse

/* File: hw/tim_top.sv */
`timescale 1ns/10ps
// Functional notes
// - Parallel mode: select pin low frames an SPI cycle, UART on dedicated pins.
// - Multiplexed, select high: SPI off, shared pins carry UART.
// - Pin mode: select pin high gives push-pull, low single-sided drive.
// - Pin mode single-sided: shared input high low-side, low high-side.
// - Pin mode: enable pin high drives line; low turns driver off.
// - Driven line level is inverse of transmit input.
// - Mux, select low, source bit clear: enable pin drives, shared input data.
// - Mux UART: shared clock pin enables driver, line inverse of shared input.
// - Receive output is inverse line; floats by bit in SPI; pin mode active.
// - Mux with select high: shared output is inverse line level.
// - Pin mode: shared output low during thermal shutdown.
// - Pin mode: shared clock pin high selects 200mA, low 100mA.
// - SPI operation: interrupt output low when any interrupt bit set.
// - Pin mode: interrupt output low while overcurrent.
// - Wake-up output pulses low 200us per valid wake-up.
// - Pin mode: indicator 1 follows its control input.
// - SPI operation: indicator 1 on if input or bit set.
// - Indicator 2 follows its bit in SPI; off in pin mode.
// - SPI line request from disable, level bit, enable and transmit.
// - Aux logic output inverse of aux input; disable bit only in SPI.
// - Port select low uses dedicated UART pins; ignored in pin mode.
// - Source bit set: port select chooses; shared inputs sampled on its fall.
module tim_top
    import tim_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Mode pins
    input wire logic interface_select_pin,
    input wire logic select_or_drive_type_pin,
    input wire logic serial_port_select,
    // Dedicated UART pins
    input wire logic line_drive_enable_pin,
    input wire logic line_transmit_input,
    output logic line_receive_output,
    output logic line_receive_oe_n,
    // Shared pins
    input wire logic shared_input_pin,
    input wire logic shared_clock_enable_limit_pin,
    output logic shared_output_pin,
    output logic shared_output_oe_n,
    // SPI engine side (same clock)
    input wire logic spi_read_data,
    output logic spi_active,
    // Configuration bits (same clock)
    input wire logic mux_select_source_bit,
    input wire logic receiver_disable_bit,
    input wire logic line_driver_disable_bit,
    input wire logic line_level_bit,
    input wire logic aux_input_disable_bit,
    input wire logic indicator1_bit,
    input wire logic indicator2_bit,
    input wire logic [1:0] spi_drive_type,
    input wire logic interrupt_pending,
    // Analog status (pins)
    input wire logic line_terminal_level,
    input wire logic overcurrent_detect,
    input wire logic thermal_shutdown,
    input wire logic wake_detect,
    input wire logic aux_digital_input,
    input wire logic indicator1_control_input,
    // Line driver controls
    output logic line_drive_high,
    output logic line_drive_low,
    output logic limit_200ma_select,
    // Misc outputs
    output logic interrupt_overcurrent_output,
    output logic interrupt_overcurrent_oe_n,
    output logic wakeup_request_output,
    output logic aux_input_logic_output,
    output logic aux_input_oe_n,
    output logic indicator1_output,
    output logic indicator2_output
);
    import tim_pkg::*;

    // ==========================================
    // Synchronised pins
    // ==========================================
    localparam int unsigned NSYNC = 13;
    logic [NSYNC-1:0] raw_pins;
    logic [NSYNC-1:0] sync_pins;
    logic ifsel_s, cs_s, serial_port_select_s, line_drive_enable_pin_s, tx_s, sdi_s, clkp_s;
    logic cq_s, oc_s, thsh_s, wake_s, di_s, indicator1_control_input_s;

    assign raw_pins = {interface_select_pin, select_or_drive_type_pin, serial_port_select,
                       line_drive_enable_pin, line_transmit_input, shared_input_pin,
                       shared_clock_enable_limit_pin, line_terminal_level,
                       overcurrent_detect, thermal_shutdown, wake_detect,
                       aux_digital_input, indicator1_control_input};

    tim_sync #(.WIDTH(NSYNC)) tim_sync_inst (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .async_in(raw_pins),
        .sync_out(sync_pins)
    );

    assign {ifsel_s, cs_s, serial_port_select_s, line_drive_enable_pin_s, tx_s, sdi_s, clkp_s,
            cq_s, oc_s, thsh_s, wake_s, di_s, indicator1_control_input_s} = sync_pins;

    // ==========================================
    // Wake-up pulse
    // ==========================================
    logic wake_prev_q;
    logic wake_active;

    // Detector output is synchronised like any pin, so the pulse starts
    // four edges after the rise; fine against a pulse of many microseconds
    // Rising edge of detector output is one valid condition
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_prev_q <= 1'b0;
        end else if (ce) begin
            wake_prev_q <= wake_s;
        end
    end

    tim_wake_pulse tim_wake_pulse_inst (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .wake_event(wake_s & ~wake_prev_q),
        .wake_active(wake_active)
    );

    // ==========================================
    // Port-select sampling
    // ==========================================
    // Shared enable and data follow the pins while port select is high and
    // freeze at its fall, so the line does not glitch while the host swaps
    // its port over to SPI traffic.
    logic held_line_drive_enable_pin_q, held_tx_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held_line_drive_enable_pin_q <= 1'b0;
            held_tx_q <= 1'b1;
        end else if (ce) begin
            if (serial_port_select_s) begin
                held_line_drive_enable_pin_q <= clkp_s;
                held_tx_q <= sdi_s;
            end
        end
    end

    // ==========================================
    // Mode decode
    // ==========================================
    // Returns the line request for an enable/transmit pair, inverting data
    function automatic tim_req_type uart_req(input logic en, input logic tx);
        if (!en) begin
            uart_req = TIM_REQ_FLOAT;
        end else begin
            uart_req = tx ? TIM_REQ_LOW : TIM_REQ_HIGH;
        end
    endfunction : uart_req

    logic pin_mode, mux_mode, mux_uart, mux_spi_data, mux_held;
    tim_drive_type drive_type;
    tim_req_type req;
    logic en_eff, tx_eff;

    assign pin_mode = !ifsel_s;
    // Serial side has three shapes:
    //   source bit clear, port select low  -> parallel, dedicated UART pins
    //   source bit clear, port select high -> chip-select picks SPI or UART
    //   source bit set                     -> port select picks SPI or UART
    // In the last shape the line keeps the enable and data captured while
    // port select was high, so SPI traffic on the shared pins never reaches
    // the line. Limitation: the line cannot be switched during SPI there.
    assign mux_mode = !pin_mode && (mux_select_source_bit || serial_port_select_s);
    // Multiplexed UART window selected by chip-select or by port select
    assign mux_uart = mux_mode && (mux_select_source_bit ? serial_port_select_s : cs_s);
    assign mux_spi_data = mux_mode && !mux_select_source_bit && !cs_s;
    assign mux_held = mux_mode && mux_select_source_bit && !serial_port_select_s;

    // Pin straps win over the serial drive-type code
    always_comb begin
        drive_type = TIM_PUSH_PULL;
        if (pin_mode) begin
            if (cs_s) begin
                drive_type = TIM_PUSH_PULL;
            end else begin
                drive_type = sdi_s ? TIM_LOW_SIDE : TIM_HIGH_SIDE;
            end
        end else begin
            case (spi_drive_type)
                2'h0: drive_type = TIM_HIGH_SIDE;
                2'h1: drive_type = TIM_LOW_SIDE;
                default: drive_type = TIM_PUSH_PULL;
            endcase
        end
    end

    // Source of enable and data for the line
    always_comb begin
        en_eff = line_drive_enable_pin_s;
        tx_eff = tx_s;
        if (mux_uart) begin
            en_eff = clkp_s;
            tx_eff = sdi_s;
        end else if (mux_spi_data) begin
            tx_eff = sdi_s;
        end else if (mux_held) begin
            en_eff = held_line_drive_enable_pin_q;
            tx_eff = held_tx_q;
        end
    end

    // Line request
    always_comb begin
        req = TIM_REQ_FLOAT;
        if (pin_mode) begin
            req = uart_req(line_drive_enable_pin_s, tx_s);
        end else if (line_driver_disable_bit) begin
            req = TIM_REQ_FLOAT;
        end else if (!en_eff) begin
            req = line_level_bit ? TIM_REQ_HIGH : TIM_REQ_FLOAT;
        end else if (tx_eff && !line_level_bit) begin
            req = TIM_REQ_LOW;
        end else begin
            req = TIM_REQ_HIGH;
        end
    end

    // ==========================================
    // Line driver outputs
    // ==========================================
    // Single-sided drive floats the opposite level
    // The limit strap only matters in pin mode; serial mode keeps it low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_drive_high <= 1'b0;
            line_drive_low <= 1'b0;
            limit_200ma_select <= 1'b0;
        end else if (ce) begin
            line_drive_high <= (req == TIM_REQ_HIGH) && (drive_type != TIM_LOW_SIDE);
            line_drive_low <= (req == TIM_REQ_LOW) && (drive_type != TIM_HIGH_SIDE);
            limit_200ma_select <= pin_mode && clkp_s;
        end
    end

    // ==========================================
    // Receiver and shared output
    // ==========================================
    // Receive output, and shared output in mux UART, follow the line through
    // the same synchroniser, so they lag the pin by three edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_receive_output <= 1'b1;
            line_receive_oe_n <= 1'b1;
            shared_output_pin <= 1'b1;
            shared_output_oe_n <= 1'b1;
            spi_active <= 1'b0;
        end else if (ce) begin
            line_receive_output <= !cq_s;
            line_receive_oe_n <= !pin_mode && receiver_disable_bit;
            spi_active <= !pin_mode && !cs_s && !mux_uart;
            if (pin_mode) begin
                shared_output_pin <= !thsh_s;
                shared_output_oe_n <= 1'b0;
            end else if (mux_uart) begin
                shared_output_pin <= !cq_s;
                shared_output_oe_n <= receiver_disable_bit;
            end else begin
                shared_output_pin <= spi_read_data;
                shared_output_oe_n <= cs_s;
            end
        end
    end

    // ==========================================
    // Interrupt, wake, aux input, indicators
    // ==========================================
    // Interrupt output is open-drain: only ever drives low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            interrupt_overcurrent_output <= 1'b0;
            interrupt_overcurrent_oe_n <= 1'b1;
            wakeup_request_output <= 1'b1;
            aux_input_logic_output <= 1'b1;
            aux_input_oe_n <= 1'b1;
            indicator1_output <= 1'b0;
            indicator2_output <= 1'b0;
        end else if (ce) begin
            interrupt_overcurrent_output <= 1'b0;
            if (pin_mode) begin
                interrupt_overcurrent_oe_n <= !oc_s;
                indicator1_output <= indicator1_control_input_s;
                indicator2_output <= 1'b0;
                aux_input_oe_n <= 1'b0;
            end else begin
                interrupt_overcurrent_oe_n <= !interrupt_pending;
                indicator1_output <= indicator1_control_input_s || indicator1_bit;
                indicator2_output <= indicator2_bit;
                aux_input_oe_n <= aux_input_disable_bit;
            end
            wakeup_request_output <= !wake_active;
            aux_input_logic_output <= !di_s;
        end
    end

endmodule : tim_top

/* File: testbench/tim_top_properties.sv */
`timescale 1ns/10ps
// ==========================================
// Port checks for the mode control block
// ==========================================
module tim_top_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Mode and status inputs
    input wire logic interface_select_pin,
    input wire logic serial_port_select,
    input wire logic shared_clock_enable_limit_pin,
    input wire logic line_terminal_level,
    input wire logic thermal_shutdown,
    input wire logic overcurrent_detect,
    input wire logic wake_detect,
    input wire logic aux_digital_input,
    input wire logic interrupt_pending,
    // Block outputs
    input wire logic line_receive_output,
    input wire logic shared_output_pin,
    input wire logic limit_200ma_select,
    input wire logic spi_active,
    input wire logic line_drive_high,
    input wire logic line_drive_low,
    input wire logic interrupt_overcurrent_oe_n,
    input wire logic wakeup_request_output,
    input wire logic aux_input_logic_output,
    input wire logic aux_input_oe_n
);
    logic pm;
    // Pin-strap mode as seen at the select pin
    assign pm = !interface_select_pin;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Four quiet edges cover two sync flops plus the output flop
    sequence s_hold(m, a);
        (m && $stable(interface_select_pin) && $stable(a))[*4];
    endsequence
    // ==========================================
    // Properties
    // ==========================================
    property p_excl;
        !(line_drive_high && line_drive_low);
    endproperty
    a_excl: assert property (p_excl) else $error("both gates on");
    property p_rx;
        s_hold(pm, line_terminal_level) |-> line_receive_output != line_terminal_level;
    endproperty
    a_rx: assert property (p_rx) else $error("receive level wrong");
    property p_th;
        s_hold(pm, thermal_shutdown) |-> shared_output_pin != thermal_shutdown;
    endproperty
    a_th: assert property (p_th) else $error("shutdown flag wrong");
    property p_lim;
        s_hold(pm, shared_clock_enable_limit_pin) |->
            limit_200ma_select == shared_clock_enable_limit_pin;
    endproperty
    a_lim: assert property (p_lim) else $error("limit select wrong");
    property p_oc;
        s_hold(pm, overcurrent_detect) |-> interrupt_overcurrent_oe_n != overcurrent_detect;
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent flag wrong");
    property p_irq;
        s_hold(!pm, interrupt_pending) |-> interrupt_overcurrent_oe_n != interrupt_pending;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt flag wrong");
    property p_wake;
        $rose(wake_detect) |-> ##[1:6] !wakeup_request_output;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse late");
    property p_aux;
        s_hold(pm, aux_digital_input) |->
            !aux_input_oe_n && aux_input_logic_output != aux_digital_input;
    endproperty
    a_aux: assert property (p_aux) else $error("aux output wrong");
    // Main scenarios reached
    c_spi: cover property ($rose(spi_active));
    c_wake: cover property ($fell(wakeup_request_output));
    c_mux: cover property (interface_select_pin && serial_port_select && line_drive_low);
endmodule : tim_top_properties

bind tim_top tim_top_properties tim_top_properties_inst (.*);

/* File: testbench/tim_host_model.sv */
`timescale 1ns/10ps
// ==========================================
// Host controller model: SPI and UART pins
// ==========================================
module tim_host_model (
    // Pacing clock
    input wire logic clk,
    // Host pins
    output logic select_or_drive_type_pin,
    output logic serial_port_select,
    output logic line_drive_enable_pin,
    output logic line_transmit_input,
    output logic shared_input_pin,
    output logic shared_clock_enable_limit_pin
);
    // Power-up: frame closed, driver held off
    initial begin
        {select_or_drive_type_pin, serial_port_select, line_drive_enable_pin} = 3'h4;
        {line_transmit_input, shared_input_pin, shared_clock_enable_limit_pin} = 3'h4;
    end
    // All pins move together just after a falling edge
    task put(input logic [5:0] v);
        @(negedge clk);
        {select_or_drive_type_pin, serial_port_select, line_drive_enable_pin,
            line_transmit_input, shared_input_pin, shared_clock_enable_limit_pin} = v;
    endtask : put
    // Shared enable low and shared transmit high, so no glitch on the line
    task enter_mux;
        put(6'h36);
    endtask : enter_mux
    // SPI frame; the link clock stands still outside it
    task frame(input logic [7:0] d);
        @(negedge clk);
        select_or_drive_type_pin = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            shared_input_pin = d[i];
            #80 shared_clock_enable_limit_pin = 1'h1;
            #80 shared_clock_enable_limit_pin = 1'h0;
        end
        #40 select_or_drive_type_pin = 1'h1;
        shared_input_pin = !d[0];
    endtask : frame
endmodule : tim_host_model

/* File: testbench/transceiver_interface_mode_control_bench.sv */
`timescale 1ns/10ps
// ==========================================
// Bench for the mode control block
// ==========================================
module transceiver_interface_mode_control_bench;
    import tim_pkg::*;
    // Clock, reset and counters
    logic clk = 1'h0, rstn = 1'h0, ce = 1'h1;
    int bad_count = 0, tests_run = 0, cycles = 0;
    // Configuration and status inputs
    logic interface_select_pin, spi_read_data, mux_select_source_bit, receiver_disable_bit;
    logic line_driver_disable_bit, line_level_bit, aux_input_disable_bit, indicator1_bit;
    logic indicator2_bit, interrupt_pending, line_terminal_level, overcurrent_detect;
    logic thermal_shutdown, wake_detect, aux_digital_input, indicator1_control_input;
    logic [1:0] spi_drive_type;
    // Host pins and block outputs
    logic select_or_drive_type_pin, serial_port_select, line_drive_enable_pin;
    logic line_transmit_input, shared_input_pin, shared_clock_enable_limit_pin;
    logic line_receive_output, line_receive_oe_n, shared_output_pin, shared_output_oe_n;
    logic spi_active, line_drive_high, line_drive_low, limit_200ma_select;
    logic interrupt_overcurrent_output, interrupt_overcurrent_oe_n, wakeup_request_output;
    logic aux_input_logic_output, aux_input_oe_n, indicator1_output, indicator2_output;

    tim_top tim_top_inst (.*);
    tim_host_model tim_host_model_inst (.*);

    // 50 MHz clock
    always #10 clk = !clk;
    // Hang guard, far above the expected 10375 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            wrap_up();
        end
    end
    // ==========================================
    // Checking helpers
    // ==========================================
    task chk(input string n, input logic e, input logic s);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %b seen %b", n, e, s);
        end
    endtask : chk
    // Driver gates as {high, low}
    task chk_drv(input logic [1:0] e);
        chk("drive high", e[1], line_drive_high);
        chk("drive low", e[0], line_drive_low);
    endtask : chk_drv
    // Past the three-edge answer; compare off the rising edge
    task settle;
        repeat (5) @(negedge clk);
    endtask : settle
    task wrap_up;
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // ==========================================
    // Scenarios
    // ==========================================
    task t_pin;
        logic [3:0] v;
        logic [1:0] e;
        interface_select_pin = 1'h0;
        {receiver_disable_bit, aux_input_disable_bit, indicator2_bit} = 3'h7;
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            tim_host_model_inst.put({v[2], v[0], v[3], v[0], v[1], v[1] ^ v[0]});
            {line_terminal_level, thermal_shutdown, overcurrent_detect} = v[2:0];
            {indicator1_control_input, aux_digital_input} = v[1:0];
            settle();
            e = !v[3] ? 2'h0 : v[0] ? {1'h0, v[2] | v[1]} : {v[2] | !v[1], 1'h0};
            chk_drv(e);
            chk("limit", v[1] ^ v[0], limit_200ma_select);
            chk("rx", !v[2], line_receive_output);
            chk("rx oe_n", 1'h0, line_receive_oe_n);
            chk("thsh", !v[1], shared_output_pin);
            chk("thsh oe_n", 1'h0, shared_output_oe_n);
            chk("irq oe_n", !v[0], interrupt_overcurrent_oe_n);
            chk("irq level", 1'h0, interrupt_overcurrent_output);
            chk("indicator1_output", v[1], indicator1_output);
            chk("indicator2_output", 1'h0, indicator2_output);
            chk("aux", !v[0], aux_input_logic_output);
            chk("aux oe_n", 1'h0, aux_input_oe_n);
        end
    endtask : t_pin
    task t_spi;
        logic [3:0] v;
        logic [1:0] e;
        interface_select_pin = 1'h1;
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            tim_host_model_inst.put({2'h2, v[1:0], v[1:0]});
            {line_driver_disable_bit, line_level_bit} = v[3:2];
            {receiver_disable_bit, aux_input_disable_bit, interrupt_pending} = v[2:0];
            {indicator1_control_input, indicator1_bit, indicator2_bit} = v[3:1];
            settle();
            e = (v[3] || (!v[1] && !v[2])) ? 2'h0 : (v[1] && v[0] && !v[2]) ? 2'h1 : 2'h2;
            chk_drv(e);
            chk("rx oe_n", v[2], line_receive_oe_n);
            chk("aux oe_n", v[1], aux_input_oe_n);
            chk("irq oe_n", !v[0], interrupt_overcurrent_oe_n);
            chk("indicator1_output", v[3] | v[2], indicator1_output);
            chk("indicator2_output", v[1], indicator2_output);
        end
    endtask : t_spi
    task t_mux;
        logic [2:0] v;
        tim_host_model_inst.enter_mux();
        {line_driver_disable_bit, line_level_bit, receiver_disable_bit} = 3'h0;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            tim_host_model_inst.put({v[2], 1'h1, v[1] & !v[2], !v[0], v[0], v[1] & v[2]});
            line_terminal_level = v[0];
            settle();
            chk_drv(v[1] ? {!v[0], v[0]} : 2'h0);
            if (v[2]) chk("mux rx", !v[0], shared_output_pin);
            if (v[2]) chk("mux rx oe_n", 1'h0, shared_output_oe_n);
        end
    endtask : t_mux
    // Source bit set: live shared pins while port select high, held after
    task t_hold;
        mux_select_source_bit = 1'h1;
        tim_host_model_inst.put(6'h37);
        settle();
        chk_drv(2'h1);
        tim_host_model_inst.put(6'h27);
        settle();
        chk_drv(2'h1);
        tim_host_model_inst.put(6'h24);
        settle();
        chk_drv(2'h1);
        chk("held sdo oe_n", 1'h1, shared_output_oe_n);
        ce = 1'h0;
        tim_host_model_inst.put(6'h34);
        settle();
        chk_drv(2'h1);
        ce = 1'h1;
        settle();
        chk_drv(2'h0);
        mux_select_source_bit = 1'h0;
    endtask : t_hold
    task t_frame;
        spi_read_data = 1'h1;
        tim_host_model_inst.put(6'h20);
        fork
            tim_host_model_inst.frame(8'ha5);
            begin
                repeat (20) @(negedge clk);
                chk("spi open", 1'h1, spi_active);
                chk("sdo", 1'h1, shared_output_pin);
                chk("sdo oe_n", 1'h0, shared_output_oe_n);
            end
        join
        settle();
        chk("spi closed", 1'h0, spi_active);
        chk("sdo off", 1'h1, shared_output_oe_n);
    endtask : t_frame
    task t_wake;
        wake_detect = 1'h1;
        repeat (10) @(negedge clk);
        wake_detect = 1'h0;
        chk("wake start", 1'h0, wakeup_request_output);
        repeat (WAKE_LOW_CYC - 20) @(negedge clk);
        chk("wake hold", 1'h0, wakeup_request_output);
        repeat (30) @(negedge clk);
        chk("wake end", 1'h1, wakeup_request_output);
    endtask : t_wake
    // Main sequence
    initial begin
        {interface_select_pin, spi_read_data, mux_select_source_bit, receiver_disable_bit} = '0;
        {line_driver_disable_bit, line_level_bit, aux_input_disable_bit, indicator1_bit} = '0;
        {indicator2_bit, interrupt_pending, line_terminal_level, overcurrent_detect} = '0;
        {thermal_shutdown, wake_detect, aux_digital_input, indicator1_control_input} = '0;
        spi_drive_type = 2'h2;
        repeat (12) @(negedge clk);
        rstn = 1'h1;
        t_pin();
        t_spi();
        t_mux();
        t_hold();
        t_frame();
        t_wake();
        wrap_up();
    end
endmodule : transceiver_interface_mode_control_bench
